// ===== tcap_timer.sv
// Free-running 16-bit timer with overflow flag and two input-capture channels.
//
// Contract
// RULE_01: A free-running 16-bit up-counter, read as high and low bytes.
// RULE_02: Counter ticks at CPU clock divided by 2, 4 or 8 per clock select.
// RULE_03: Both clock-select bits one selects the external timer clock pin.
// RULE_04: External mode counts only on the edge chosen by the edge-select bit.
// RULE_05: External clock is synchronised to the CPU clock before counting.
// RULE_06: External clock leaves at least four CPU clocks between active edges.
// RULE_07: Alternate view returns same count; its low byte never clears overflow.
// RULE_08: Writing either low counter byte, or reset, loads FFFCh.
// RULE_09: High byte read latches low byte until low byte is read.
// RULE_10: After a completed sequence, a low-only read returns the live low byte.
// RULE_11: Overflow flag sets when counter wraps from FFFFh to 0000h.
// RULE_12: Overflow interrupt requested while enabled and global mask clear.
// RULE_13: Overflow flag clears after status read then main low byte access.
// RULE_14: Counter runs in wait, holds in halt, resumes after wake-up.
// RULE_15: Active capture edge copies counter to capture register and sets flag.
// RULE_16: Each capture channel has its own edge-select bit.
// RULE_17: One capture enable covers both channels, gated by global mask.
// RULE_18: Capture flag clears after status read then capture low byte access.
// RULE_19: An unbonded timer input reads constantly one.
// RULE_20: Capture high read blocks captures and flag until capture low read.
// RULE_21: Capture inputs are synchronised before edge detection.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/100ps
module tcap_timer
   import tcap_pkg::*;
#(
   parameter bit CAP1_BONDED = 1'b1,
   parameter bit CAP2_BONDED = 1'b1,
   parameter bit EXT_BONDED = 1'b1
)
(
   input wire logic clk,
   input wire logic srst,
   input tcap_pkg::tcap_req_t req,
   output logic [7:0] rdata,
   input wire logic capture_input_one,
   input wire logic capture_input_two,
   input wire logic ext_timer_clock_pin,
   input wire logic cpu_irq_mask,
   input wire logic halt_mode,
   output logic timer_irq
);
   import tcap_pkg::*;

   logic [15:0] count;
   logic [7:0] control_reg_one;
   logic [7:0] control_reg_two;
   logic overflow_flag;
   logic [1:0] capture_flag_n;
   logic [15:0] cap_val [2];
   logic [1:0] cap_blocked;
   logic [7:0] low_latch;
   logic low_latched;
   logic ovf_armed;
   logic [1:0] cap_armed;
   logic [2:0] prescale;
   logic [2:0] ext_sync;
   logic [2:0] cap1_sync;
   logic [2:0] cap2_sync;
   logic [2:0] sync_warm;
   logic [1:0] timer_clock_select;
   logic tick;
   logic wrap;
   logic ext_edge;
   logic [1:0] cap_edge;
   logic [1:0] pin_now;
   logic [1:0] pin_old;
   logic [1:0] edge_sel;
   logic sr_read;
   logic main_lo_access;
   logic any_lo_write;
   logic [1:0] cap_lo_access;
   logic [1:0] cap_hi_read;
   logic [7:0] next_rdata;

   // ************************************************************
   // Input conditioning
   // ************************************************************

   // RULE_19 unbonded inputs one
   // Unbonded pins are forced high before the synchronisers.
   logic ext_pin;
   logic cap1_pin;
   logic cap2_pin;
   assign ext_pin = EXT_BONDED ? ext_timer_clock_pin : 1'b1;
   assign cap1_pin = CAP1_BONDED ? capture_input_one : 1'b1;
   assign cap2_pin = CAP2_BONDED ? capture_input_two : 1'b1;

   // RULE_05 external clock sync
   // RULE_21 capture input sync
   // Stage 0 feeds stage 1 only; edges are found between stages 1 and 2.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ext_sync <= 3'h7;
         cap1_sync <= 3'h7;
         cap2_sync <= 3'h7;
         sync_warm <= 3'h0;
      end
      else
      begin
         // The reset fill is not a pin sample, so edges wait until stage 2 holds one.
         sync_warm <= {sync_warm[1:0], 1'b1};
         ext_sync <= {ext_sync[1:0], ext_pin};
         cap1_sync <= {cap1_sync[1:0], cap1_pin};
         cap2_sync <= {cap2_sync[1:0], cap2_pin};
      end
   end

   // RULE_04 external edge select
   // Edge select one means rising, zero means falling, for all three inputs.
   // A pin that idles low would otherwise show a false falling edge after reset.
   assign ext_edge = sync_warm[2] && (control_reg_two[CR2_EXT_EDGE]
                                      ? (ext_sync[1] & ~ext_sync[2])
                                      : (~ext_sync[1] & ext_sync[2]));
   // RULE_16 per-channel edge select
   assign edge_sel = {control_reg_two[CR2_EDGE2], control_reg_one[CR1_EDGE1]};
   assign pin_now = {cap2_sync[1], cap1_sync[1]};
   assign pin_old = {cap2_sync[2], cap1_sync[2]};
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         cap_edge[i] = sync_warm[2] &&
            (edge_sel[i] ? (pin_now[i] & ~pin_old[i]) : (~pin_now[i] & pin_old[i]));
      end
   end

   // ************************************************************
   // Prescaler and counter
   // ************************************************************

   assign timer_clock_select = control_reg_two[CR2_CLK_HI:CR2_CLK_LO];

   // Prescaler free-runs; halt freezes it so the count is held exactly.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         prescale <= 3'h0;
      end
      else if (!halt_mode)
      begin
         prescale <= prescale + 3'h1;
      end
   end

   // RULE_02 divided clock tick
   // RULE_03 external clock select
   // RULE_14 halt holds count
   always_comb
   begin
      tick = 1'b0;
      if (!halt_mode)
      begin
         case (timer_clock_select)
            CLK_DIV2: tick = (prescale[0] == 1'b1);
            CLK_DIV4: tick = (prescale[1:0] == 2'h3);
            CLK_DIV8: tick = (prescale == 3'h7);
            default: tick = ext_edge;
         endcase
      end
   end

   // A reload in the same cycle means the counter never reached zero.
   assign wrap = tick && (count == COUNT_MAX) && !any_lo_write;

   // RULE_08 reload on low write
   // RULE_01 free running counter
   // A write to a low byte wins over a tick in the same cycle.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         count <= COUNT_RELOAD;
      end
      else if (any_lo_write)
      begin
         count <= COUNT_RELOAD;
      end
      else if (tick)
      begin
         count <= count + 16'h0001;
      end
   end

   // ************************************************************
   // Access decode
   // ************************************************************

   assign sr_read = req.rd && (req.addr == OFF_STATUS);
   // RULE_07 alternate view no clear
   assign main_lo_access = (req.rd || req.wr) && (req.addr == OFF_CNT_LO);
   assign any_lo_write = req.wr && ((req.addr == OFF_CNT_LO) || (req.addr == OFF_ALT_LO));
   assign cap_lo_access[0] = (req.rd || req.wr) && (req.addr == OFF_CAP1_LO);
   assign cap_lo_access[1] = (req.rd || req.wr) && (req.addr == OFF_CAP2_LO);
   assign cap_hi_read[0] = req.rd && (req.addr == OFF_CAP1_HI);
   assign cap_hi_read[1] = req.rd && (req.addr == OFF_CAP2_HI);

   // Control registers; only the documented fields steer logic.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         control_reg_one <= CTRL_RESET;
         control_reg_two <= CTRL_RESET;
      end
      else if (req.wr)
      begin
         if (req.addr == OFF_CTRL_ONE)
         begin
            control_reg_one <= req.wdata;
         end
         else if (req.addr == OFF_CTRL_TWO)
         begin
            control_reg_two <= req.wdata;
         end
      end
   end

   // RULE_09 high read latches low
   // RULE_10 live low after sequence
   // One latch serves both views, so mixing views still completes a sequence.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         low_latch <= 8'h00;
         low_latched <= 1'b0;
      end
      else if (req.rd && ((req.addr == OFF_CNT_HI) || (req.addr == OFF_ALT_HI)))
      begin
         if (!low_latched)
         begin
            low_latch <= count[7:0];
         end
         low_latched <= 1'b1;
      end
      else if (req.rd && ((req.addr == OFF_CNT_LO) || (req.addr == OFF_ALT_LO)))
      begin
         low_latched <= 1'b0;
      end
   end

   // ************************************************************
   // Flags
   // ************************************************************

   // RULE_11 overflow flag set
   // RULE_13 two step clear
   // A wrap in the clearing cycle keeps the flag set.
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         overflow_flag <= 1'b0;
         ovf_armed <= 1'b0;
      end
      else
      begin
         if (wrap)
         begin
            overflow_flag <= 1'b1;
         end
         else if (ovf_armed && main_lo_access)
         begin
            overflow_flag <= 1'b0;
         end
         if (sr_read && overflow_flag)
         begin
            ovf_armed <= 1'b1;
         end
         else if (main_lo_access)
         begin
            ovf_armed <= 1'b0;
         end
      end
   end

   // RULE_15 capture copies counter
   // RULE_18 capture two step clear
   // RULE_20 high read blocks capture
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         capture_flag_n <= 2'h0;
         cap_armed <= 2'h0;
         cap_blocked <= 2'h0;
         cap_val[0] <= 16'h0000;
         cap_val[1] <= 16'h0000;
      end
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (cap_edge[i] && !cap_blocked[i])
            begin
               cap_val[i] <= count;
               capture_flag_n[i] <= 1'b1;
            end
            else if (cap_armed[i] && cap_lo_access[i])
            begin
               capture_flag_n[i] <= 1'b0;
            end
            if (sr_read && capture_flag_n[i])
            begin
               cap_armed[i] <= 1'b1;
            end
            else if (cap_lo_access[i])
            begin
               cap_armed[i] <= 1'b0;
            end
            if (cap_hi_read[i])
            begin
               cap_blocked[i] <= 1'b1;
            end
            else if (req.rd && cap_lo_access[i])
            begin
               cap_blocked[i] <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // Read data and interrupt
   // ************************************************************

   // Unmapped offsets read as zero.
   always_comb
   begin
      next_rdata = 8'h00;
      if (req.addr == OFF_CTRL_ONE)
         next_rdata = control_reg_one;
      else if (req.addr == OFF_CTRL_TWO)
         next_rdata = control_reg_two;
      else if (req.addr == OFF_STATUS)
         next_rdata = {capture_flag_n[0], capture_flag_n[1], overflow_flag, 5'h00};
      else if ((req.addr == OFF_CNT_HI) || (req.addr == OFF_ALT_HI))
         next_rdata = count[15:8];
      else if ((req.addr == OFF_CNT_LO) || (req.addr == OFF_ALT_LO))
         next_rdata = low_latched ? low_latch : count[7:0];
      else if (req.addr == OFF_CAP1_HI)
         next_rdata = cap_val[0][15:8];
      else if (req.addr == OFF_CAP1_LO)
         next_rdata = cap_val[0][7:0];
      else if (req.addr == OFF_CAP2_HI)
         next_rdata = cap_val[1][15:8];
      else if (req.addr == OFF_CAP2_LO)
         next_rdata = cap_val[1][7:0];
   end

   // Read data stands only in the cycle after the strobe.
   always_ff @(posedge clk)
   begin
      if (srst)
         rdata <= 8'h00;
      else if (req.rd)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

   // RULE_12 overflow interrupt gate
   // RULE_17 shared capture enable
   // Flags stay set while masked, so the request is pending until unmasked.
   always_ff @(posedge clk)
   begin
      if (srst)
         timer_irq <= 1'b0;
      else
         timer_irq <= !cpu_irq_mask &&
            ((overflow_flag && control_reg_one[CR1_OVF_IE]) ||
             ((|capture_flag_n) && control_reg_one[CR1_CAP_IE]));
   end

   // ************************************************************
   // Checks
   // ************************************************************

   a_reload_on_write: assert property (@(posedge clk) disable iff (srst) // RULE_08
      any_lo_write |=> count == COUNT_RELOAD)
      else $error("Low byte write did not reload counter.");

   a_wrap_sets_flag: assert property (@(posedge clk) disable iff (srst) // RULE_11
      wrap |=> overflow_flag && count == 16'h0000)
      else $error("Wrap did not set overflow flag.");

   a_alt_keeps_flag: assert property (@(posedge clk) disable iff (srst) // RULE_07
      (overflow_flag && req.rd && req.addr == OFF_ALT_LO && !main_lo_access) |=> overflow_flag)
      else $error("Alternate low read cleared overflow.");

   a_halt_holds: assert property (@(posedge clk) disable iff (srst) // RULE_14
      (halt_mode && !any_lo_write) |=> $stable(count))
      else $error("Counter moved during halt.");

   a_div8_spacing: assert property (@(posedge clk) disable iff (srst) // RULE_02
      (tick && timer_clock_select == CLK_DIV8 && !halt_mode) |=> !tick [*7])
      else $error("Divide by 8 ticked too often.");

   a_latch_frozen: assert property (@(posedge clk) disable iff (srst) // RULE_09
      (low_latched && !(req.rd && (req.addr == OFF_CNT_LO || req.addr == OFF_ALT_LO)))
      |=> $stable(low_latch) && low_latched)
      else $error("Latched low byte changed.");

   a_capture_block: assert property (@(posedge clk) disable iff (srst) // RULE_20
      cap_blocked[0] |=> $stable(cap_val[0]))
      else $error("Blocked capture channel updated.");

   a_capture_two_block: assert property (@(posedge clk) disable iff (srst) // RULE_20
      cap_blocked[1] |=> $stable(cap_val[1]) && !$rose(capture_flag_n[1]))
      else $error("Blocked capture channel two updated.");

   a_irq_gate: assert property (@(posedge clk) disable iff (srst) // RULE_12
      (overflow_flag && control_reg_one[CR1_OVF_IE] && !cpu_irq_mask) |=> timer_irq)
      else $error("Overflow interrupt not raised.");

endmodule

// ===== tcap_pkg.sv
// Package with register offsets, field positions and reset values for the capture timer.
package tcap_pkg;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [3:0] OFF_CTRL_ONE = 4'h0;
   localparam logic [3:0] OFF_CTRL_TWO = 4'h1;
   localparam logic [3:0] OFF_STATUS = 4'h2;
   localparam logic [3:0] OFF_CAP1_HI = 4'h3;
   localparam logic [3:0] OFF_CAP1_LO = 4'h4;
   localparam logic [3:0] OFF_CNT_HI = 4'h8;
   localparam logic [3:0] OFF_CNT_LO = 4'h9;
   localparam logic [3:0] OFF_ALT_HI = 4'ha;
   localparam logic [3:0] OFF_ALT_LO = 4'hb;
   localparam logic [3:0] OFF_CAP2_HI = 4'hc;
   localparam logic [3:0] OFF_CAP2_LO = 4'hd;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CR1_CAP_IE = 7;
   localparam int CR1_OVF_IE = 5;
   localparam int CR1_EDGE1 = 1;
   localparam int CR2_CLK_HI = 3;
   localparam int CR2_CLK_LO = 2;
   localparam int CR2_EDGE2 = 1;
   localparam int CR2_EXT_EDGE = 0;
   localparam int SR_CAP1 = 7;
   localparam int SR_CAP2 = 6;
   localparam int SR_OVF = 5;

   // ************************************************************
   // Reset values and modes
   // ************************************************************
   localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] CLK_DIV2 = 2'h0;
   localparam logic [1:0] CLK_DIV4 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   localparam logic [2:0] EXT_SYNC_STAGES = 3'h4;

   // Register port request grouped together.
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } tcap_req_t;

endpackage

// ===== tcap_partner.sv
// Far-side model that drives the capture pins and the external timer clock.
`timescale 1ns/100ps
module tcap_partner
(
   input wire logic clk,
   output logic capture_input_one,
   output logic capture_input_two,
   output logic ext_timer_clock_pin
);

   // ************************************************************
   // Pin drivers
   // ************************************************************

   // All pins start low so the first move of each is a clean rising edge.
   initial
   begin
      capture_input_one = 1'b0;
      capture_input_two = 1'b0;
      ext_timer_clock_pin = 1'b0;
   end

   // Moves one capture pin, then waits long enough for the synchroniser and capture.
   task automatic set_cap(input int ch, input logic v);
      @(posedge clk);
      if (ch == 1)
      begin
         capture_input_one <= v;
      end
      else
      begin
         capture_input_two <= v;
      end
      repeat (6) @(posedge clk);
   endtask

   // spaced external edges
   // Each level is held at least seven clocks, so active edges are at least fourteen clocks apart.
   task automatic ext_level(input logic v);
      @(posedge clk);
      ext_timer_clock_pin <= v;
      repeat (6) @(posedge clk);
   endtask

endmodule

// ===== tcap_timer_tb_top.sv
// Self-checking testbench for the capture timer.
`timescale 1ns/100ps
module tcap_timer_tb_top;
   import tcap_pkg::*;

   logic clk = 1'b0;
   logic srst;
   tcap_req_t req;
   logic [7:0] rdata;
   logic [7:0] rdata_ub;
   logic [7:0] ub;
   logic capture_input_one;
   logic capture_input_two;
   logic ext_timer_clock_pin;
   logic cpu_irq_mask;
   logic halt_mode;
   logic timer_irq;
   int n_errors = 0;
   int n_compared = 0;
   logic [7:0] hi;
   logic [7:0] lo;
   logic [15:0] diff;

   // ************************************************************
   // Clock, design and far side
   // ************************************************************

   // A 20 ns clock.
   always #10 clk = ~clk;

   tcap_timer dut
   (
      .clk(clk),
      .srst(srst),
      .req(req),
      .rdata(rdata),
      .capture_input_one(capture_input_one),
      .capture_input_two(capture_input_two),
      .ext_timer_clock_pin(ext_timer_clock_pin),
      .cpu_irq_mask(cpu_irq_mask),
      .halt_mode(halt_mode),
      .timer_irq(timer_irq)
   );

   // unbonded copy
   // A second copy with every timer input unbonded sees the same bus traffic.
   tcap_timer #(.CAP1_BONDED(1'b0), .CAP2_BONDED(1'b0), .EXT_BONDED(1'b0)) dut_unbonded
   (
      .clk(clk),
      .srst(srst),
      .req(req),
      .rdata(rdata_ub),
      .capture_input_one(capture_input_one),
      .capture_input_two(capture_input_two),
      .ext_timer_clock_pin(ext_timer_clock_pin),
      .cpu_irq_mask(cpu_irq_mask),
      .halt_mode(halt_mode),
      .timer_irq()
   );

   tcap_partner partner
   (
      .clk(clk),
      .capture_input_one(capture_input_one),
      .capture_input_two(capture_input_two),
      .ext_timer_clock_pin(ext_timer_clock_pin)
   );

   // ************************************************************
   // Tasks
   // ************************************************************

   // Prints the counts and the verdict, then stops the run.
   task automatic finish_test;
      $display("Compared %0d values, %0d mismatches", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
      begin
         $display("No errors found");
      end
      else
      begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Case equality so an unknown never passes as a match.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         n_errors++;
      end
   endtask

   // One-cycle write strobe.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask

   // One-cycle read strobe; data is taken just after the edge that accepts it.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      d = rdata;
      ub = rdata_ub;
   endtask

   // Read and compare.
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // The request is registered, so give it a few clocks before looking.
   task automatic irqc(input logic exp);
      repeat (3) @(posedge clk);
      #1;
      chk({7'h00, timer_irq}, {7'h00, exp});
   endtask

   // Two external levels make exactly one active edge in either edge mode.
   task automatic bump;
      partner.ext_level(1'b0);
      partner.ext_level(1'b1);
   endtask

   // ************************************************************
   // Tests
   // ************************************************************

   // Main sequence; the external clock keeps the count exact for most checks.
   initial
   begin
      srst <= 1'b1;
      req <= '0;
      cpu_irq_mask <= 1'b1;
      halt_mode <= 1'b0;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      rdc(OFF_STATUS, 8'h00);
      rdc(OFF_CNT_HI, 8'hff);
      rdc(OFF_CTRL_ONE, CTRL_RESET);
      rdc(OFF_CTRL_TWO, CTRL_RESET);
      rd(OFF_CNT_LO, lo);
      wr(OFF_CTRL_TWO, 8'h0d);
      rd(OFF_STATUS, lo);
      wr(OFF_CNT_LO, 8'h00);
      rdc(OFF_STATUS, 8'h00);
      rdc(OFF_CNT_HI, 8'hff);
      rdc(OFF_CNT_LO, 8'hfc);
      partner.ext_level(1'b1);
      rdc(OFF_CNT_LO, 8'hfd);
      partner.ext_level(1'b0);
      rdc(OFF_CNT_LO, 8'hfd);
      wr(OFF_CTRL_TWO, 8'h0c);
      partner.ext_level(1'b1);
      rdc(OFF_CNT_LO, 8'hfd);
      partner.ext_level(1'b0);
      rdc(OFF_CNT_LO, 8'hfe);
      wr(OFF_CTRL_TWO, 8'h0d);
      partner.ext_level(1'b1);
      rdc(OFF_ALT_HI, 8'hff);
      bump();
      rdc(OFF_ALT_HI, 8'h00);
      rdc(OFF_ALT_LO, 8'hff);
      rdc(OFF_ALT_LO, 8'h00);
      irqc(1'b0);
      wr(OFF_CTRL_ONE, 8'h20);
      irqc(1'b0);
      @(posedge clk);
      cpu_irq_mask <= 1'b0;
      irqc(1'b1);
      rdc(OFF_STATUS, 8'h20);
      rdc(OFF_ALT_LO, 8'h00);
      rdc(OFF_STATUS, 8'h20);
      rdc(OFF_CNT_LO, 8'h00);
      rdc(OFF_STATUS, 8'h00);
      irqc(1'b0);
      // Channel one on rising edges, capture interrupt on.
      wr(OFF_CTRL_ONE, 8'h82);
      bump();
      partner.set_cap(1, 1'b1);
      rdc(OFF_STATUS, 8'h80);
      irqc(1'b1);
      rdc(OFF_CAP1_HI, 8'h00);
      rdc(OFF_CAP1_LO, 8'h01);
      rdc(OFF_STATUS, 8'h00);
      rdc(OFF_CAP1_LO, 8'h01);
      rdc(OFF_STATUS, 8'h00);
      irqc(1'b0);
      partner.set_cap(1, 1'b0);
      rdc(OFF_STATUS, 8'h00);
      // Channel two on falling edges.
      bump();
      partner.set_cap(2, 1'b1);
      rdc(OFF_STATUS, 8'h00);
      partner.set_cap(2, 1'b0);
      rdc(OFF_STATUS, 8'h40);
      rdc(OFF_CAP2_HI, 8'h00);
      rdc(OFF_CAP2_LO, 8'h02);
      rdc(OFF_STATUS, 8'h00);
      rdc(OFF_CAP2_LO, 8'h02);
      rdc(OFF_STATUS, 8'h00);
      rdc(OFF_CAP2_HI, 8'h00);
      bump();
      partner.set_cap(2, 1'b1);
      partner.set_cap(2, 1'b0);
      rdc(OFF_STATUS, 8'h00);
      rdc(OFF_CAP2_LO, 8'h02);
      partner.set_cap(2, 1'b1);
      partner.set_cap(2, 1'b0);
      rdc(OFF_STATUS, 8'h40);
      chk(ub, 8'h00);
      rdc(OFF_CAP2_LO, 8'h03);
      // Halt freezes the count; it resumes from the held value.
      @(posedge clk);
      halt_mode <= 1'b1;
      bump();
      rdc(OFF_CNT_LO, 8'h03);
      chk(ub, 8'hfc);
      @(posedge clk);
      halt_mode <= 1'b0;
      bump();
      rdc(OFF_CNT_LO, 8'h04);
      // Prescaler phase is free, so accept 0fh to 12h ticks per divider.
      for (int k = 0; k < 3; k++)
      begin
         wr(OFF_CTRL_TWO, {4'h0, k[1:0], 2'b00});
         wr(OFF_CNT_LO, 8'h00);
         repeat (32 << k) @(posedge clk);
         rd(OFF_CNT_HI, hi);
         rd(OFF_CNT_LO, lo);
         diff = {hi, lo} - COUNT_RELOAD;
         n_compared++;
         if (diff < 16'h000f || diff > 16'h0012)
         begin
            $display("CHECK FAILED at %0t: got %h expected %h", $time, diff, 16'h0010);
            n_errors++;
         end
      end
      finish_test();
   end

   // Watchdog: the tests need under a thousand clocks.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_errors++;
      finish_test();
   end

endmodule
